// *** pkg/mtrs_pkg.sv ***
package mtrs_pkg;
   // instruction codes
   localparam int IR_W = 3;
   localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] IR_IDENT = 3'h1;
   localparam logic [IR_W-1:0] IR_FLOAT = 3'h2;
   localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
   localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
   // identification layout
   localparam int ID_W = 32;
   localparam int ID_START_POS = 0;
   localparam logic ID_START_BIT = 1'h1;
   localparam int MAKER_LSB = 1;
   localparam int MAKER_W = 11;
   localparam int DEV_LSB = 12;
   localparam int DEV_W = 20;
   // boundary chain layout, bit index = cell number - 1
   localparam int CHAIN_W = 129;
   localparam int RING_W = 128;
   localparam int GATE_CELL = 128;
   localparam int Q_CELL_LSB = 0;
   localparam int ECHO_W = 2;
   localparam logic INTERNAL_CAPTURE = 1'h1;
   localparam logic BYPASS_CAPTURE = 1'h0;
   // clock-domain reset values
   localparam logic OE_RESET = 1'h0;
   localparam logic RUN_RESET = 1'h1;
   localparam logic TERM_RESET = 1'h0;

   typedef enum logic [3:0] {
      TLR, IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
   } mtrs_state_e;
endpackage : mtrs_pkg

// *** hdl/mtrs_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// RQ1: test registers sample on rising test clock, change serial output on falling edge
// RQ2: instruction register is 3 bits, loads 001 at reset, reset state, capture-IR
// RQ3: instruction register shifts in shift-IR; new code acts only at update-IR
// RQ4: codes 000 extest, 001 ident, 010 float-capture, 100 sample, 111 bypass
// RQ5: under extest boundary cells drive read data, valid and echo clock pins
// RQ6: shifted boundary data reaches the pins only at update-DR
// RQ7: float-capture instruction forces read data drivers to high impedance
// RQ8: extest or float-capture disables input termination on every input
// RQ9: sample loads the I/O ring at capture-DR and shifts it in shift-DR
// RQ10: bypass is one stage, the shortest path from data in to out
// RQ11: bypass stage loads 0 at capture-DR
// RQ12: identification loads fixed code at capture-DR and shifts in shift-DR
// RQ13: identification bit 0 is 1, maker code 11:1, device content 31:12
// RQ14: identification shifts in at bit 31, bit 0 leaves first
// RQ15: boundary chain has 129 cells, captures and shifts for extest, sample, float-capture
// RQ16: not-used pin cells capture the pin level; unconnected cells capture 0
// RQ17: internal cell 129 always captures 1
// RQ18: under extest cell 129 enables read data drivers, 0 floats them
// RQ19: controller resets at power-up or after five rising edges with mode select high
// RQ20: test data out driven only in shift-IR and shift-DR
// RQ21: normal memory operation continues except under extest and float-capture
// RQ22: boundary chain shifts into cell 129, cell 1 leaves first
// RQ23: reserved codes behave as bypass, leaving outputs and termination alone
module mtrs_top
#(
   parameter int Q_W = 36,
   parameter logic [mtrs_pkg::RING_W-1:0] NC_MASK = '0,
   parameter logic [mtrs_pkg::MAKER_W-1:0] MAKER_CODE = 11'h2a5, // arbitrary value
   parameter logic [mtrs_pkg::DEV_W-1:0] DEVICE_CODE = 20'h0c3e9 // arbitrary value
)
(
   // core clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // test access port
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE,
   // core side
   input wire logic [Q_W-1:0] CORE_Q,
   input wire logic CORE_VALID,
   input wire logic [mtrs_pkg::ECHO_W-1:0] CORE_ECHO,
   input wire logic CORE_TERM_EN,
   // pad ring
   input wire logic [mtrs_pkg::RING_W-1:0] RING_IN,
   output logic [Q_W-1:0] Q_OUT,
   output logic Q_OE,
   output logic READ_VALID_OUT,
   output logic [mtrs_pkg::ECHO_W-1:0] ECHO_CLOCK_OUT,
   output logic INPUT_TERMINATION,
   output logic CORE_RUN
);
   import mtrs_pkg::*;

   localparam int VALID_CELL = Q_CELL_LSB + Q_W;
   localparam int ECHO_CELL = VALID_CELL + 1;
   localparam int OUT_W = Q_W + 1 + ECHO_W;

   generate
      if (Q_W < 1 || Q_CELL_LSB + OUT_W > RING_W)
      begin : g_bad_width
         $error("Q_W does not fit the boundary chain");
      end
   endgenerate

   // test clock domain
   logic rst_s1;
   logic rst_s2;
   logic [RING_W-1:0] ring_s1;
   logic [RING_W-1:0] ring_s2;
   mtrs_state_e state;
   mtrs_state_e next_state;
   logic [IR_W-1:0] instruction_reg;
   logic [IR_W-1:0] ir_shift;
   logic bypass_stage;
   logic [ID_W-1:0] id_shift;
   logic [CHAIN_W-1:0] boundary_chain;
   logic [OUT_W-1:0] upd_cells;
   logic upd_gate;
   logic upd_toggle;

   // core clock domain
   logic ext_s1;
   logic ext_s2;
   logic flt_s1;
   logic flt_s2;
   logic tog_s1;
   logic tog_s2;
   logic tog_s3;
   logic [OUT_W-1:0] ext_cells;
   logic ext_gate;

   wire tck_rst = ~rst_s2;
   wire sel_extest = (instruction_reg == IR_EXTEST);
   wire sel_float = (instruction_reg == IR_FLOAT);
   wire sel_sample = (instruction_reg == IR_SAMPLE);
   wire sel_ident = (instruction_reg == IR_IDENT);
   wire sel_chain = sel_extest | sel_float | sel_sample;
   wire sel_bypass = ~sel_chain & ~sel_ident; // RQ23
   wire in_shift = (state == SHIFT_IR) || (state == SHIFT_DR);
   wire [ID_W-1:0] id_value = {DEVICE_CODE, MAKER_CODE, ID_START_BIT}; // RQ13
   wire [CHAIN_W-1:0] chain_capture = {INTERNAL_CAPTURE, ring_s2 & ~NC_MASK}; // RQ16 RQ17
   wire dr_out = sel_chain ? boundary_chain[0] : (sel_ident ? id_shift[0] : bypass_stage);
   wire tdo_pick = (state == SHIFT_IR) ? ir_shift[0] : dr_out;
   wire upd_seen = tog_s2 ^ tog_s3;
   wire test_owns = ext_s2 | flt_s2;

   // power-up reset and pad levels into the test clock domain
   always_ff @(posedge TCK)
   begin
      rst_s1 <= RST_N;
      rst_s2 <= rst_s1;
      ring_s1 <= RING_IN;
      ring_s2 <= ring_s1;
   end

   // controller sequence
   always_comb
   begin
      next_state = state;
      case (state)
         TLR: next_state = TMS ? TLR : IDLE;
         IDLE: next_state = TMS ? SEL_DR : IDLE;
         SEL_DR: next_state = TMS ? SEL_IR : CAP_DR;
         CAP_DR: next_state = TMS ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR: next_state = TMS ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR: next_state = TMS ? UPD_DR : PAUSE_DR;
         PAUSE_DR: next_state = TMS ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR: next_state = TMS ? UPD_DR : SHIFT_DR;
         UPD_DR: next_state = TMS ? SEL_DR : IDLE;
         SEL_IR: next_state = TMS ? TLR : CAP_IR;
         CAP_IR: next_state = TMS ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR: next_state = TMS ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR: next_state = TMS ? UPD_IR : PAUSE_IR;
         PAUSE_IR: next_state = TMS ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR: next_state = TMS ? UPD_IR : SHIFT_IR;
         UPD_IR: next_state = TMS ? SEL_DR : IDLE;
         default: next_state = TLR;
      endcase
   end

   always_ff @(posedge TCK)
   begin
      if (tck_rst)
         state <= TLR; // RQ19
      else
         state <= next_state;
   end

   // instruction path
   always_ff @(posedge TCK)
   begin
      if (tck_rst || state == TLR)
         instruction_reg <= IR_IDENT; // RQ2
      else if (state == UPD_IR)
         instruction_reg <= ir_shift; // RQ3 RQ4
   end

   always_ff @(posedge TCK)
   begin
      if (state == CAP_IR)
         ir_shift <= IR_IDENT; // RQ2
      else if (state == SHIFT_IR)
         ir_shift <= {TDI, ir_shift[IR_W-1:1]}; // RQ1 RQ3
   end

   // data registers
   always_ff @(posedge TCK)
   begin
      if (state == CAP_DR && sel_bypass)
         bypass_stage <= BYPASS_CAPTURE; // RQ11
      else if (state == SHIFT_DR && sel_bypass)
         bypass_stage <= TDI; // RQ10
   end

   always_ff @(posedge TCK)
   begin
      if (state == CAP_DR && sel_ident)
         id_shift <= id_value; // RQ12
      else if (state == SHIFT_DR && sel_ident)
         id_shift <= {TDI, id_shift[ID_W-1:1]}; // RQ14
   end

   always_ff @(posedge TCK)
   begin
      if (state == CAP_DR && sel_chain)
         boundary_chain <= chain_capture; // RQ9 RQ15
      else if (state == SHIFT_DR && sel_chain)
         boundary_chain <= {TDI, boundary_chain[CHAIN_W-1:1]}; // RQ22
   end

   // update stage, handed over by toggle
   always_ff @(posedge TCK)
   begin
      if (tck_rst)
      begin
         upd_cells <= '0;
         upd_gate <= OE_RESET;
         upd_toggle <= 1'b0;
      end
      else if (state == UPD_DR && sel_extest)
      begin
         upd_cells <= boundary_chain[Q_CELL_LSB +: OUT_W]; // RQ6
         upd_gate <= boundary_chain[GATE_CELL]; // RQ18
         upd_toggle <= ~upd_toggle;
      end
   end

   // serial out on the falling edge
   always_ff @(negedge TCK)
   begin
      if (tck_rst)
      begin
         TDO <= 1'b0;
         TDO_OE <= 1'b0;
      end
      else
      begin
         TDO <= tdo_pick; // RQ1
         TDO_OE <= in_shift; // RQ20
      end
   end

   // crossings into the core clock domain
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         flt_s1 <= 1'b0;
         flt_s2 <= 1'b0;
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
      end
      else
      begin
         ext_s1 <= sel_extest;
         ext_s2 <= ext_s1;
         flt_s1 <= sel_float;
         flt_s2 <= flt_s1;
         tog_s1 <= upd_toggle;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         ext_cells <= '0;
         ext_gate <= OE_RESET;
      end
      else if (upd_seen)
      begin
         ext_cells <= upd_cells; // RQ6
         ext_gate <= upd_gate;
      end
   end

   // pad drivers
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         Q_OUT <= '0;
         Q_OE <= OE_RESET;
         READ_VALID_OUT <= 1'b0;
         ECHO_CLOCK_OUT <= '0;
         INPUT_TERMINATION <= TERM_RESET;
         CORE_RUN <= RUN_RESET;
      end
      else
      begin
         Q_OUT <= ext_s2 ? ext_cells[Q_W-1:0] : CORE_Q; // RQ5
         READ_VALID_OUT <= ext_s2 ? ext_cells[Q_W] : CORE_VALID; // RQ5
         ECHO_CLOCK_OUT <= ext_s2 ? ext_cells[Q_W+1 +: ECHO_W] : CORE_ECHO; // RQ5
         Q_OE <= ext_s2 ? ext_gate : ~flt_s2; // RQ7 RQ18
         INPUT_TERMINATION <= CORE_TERM_EN & ~test_owns; // RQ8
         CORE_RUN <= ~test_owns; // RQ21
      end
   end

   // checks in the test clock domain
   chk_ir_reset_load: assert property (@(posedge TCK) disable iff (tck_rst) // RQ2
      (state == TLR) |=> (instruction_reg == IR_IDENT))
      else $error("instruction not reloaded in reset state");

   chk_five_ones: assert property (@(posedge TCK) disable iff (tck_rst) // RQ19
      TMS [*5] |=> (state == TLR))
      else $error("controller missed reset after five ones");

   chk_ir_shift_hold: assert property (@(posedge TCK) disable iff (tck_rst) // RQ3
      (state == SHIFT_IR) |=> $stable(instruction_reg))
      else $error("instruction changed while shifting");

   chk_bypass_zero: assert property (@(posedge TCK) disable iff (tck_rst) // RQ11
      (state == CAP_DR && sel_bypass) |=> !bypass_stage)
      else $error("bypass stage did not capture zero");

   chk_id_capture: assert property (@(posedge TCK) disable iff (tck_rst) // RQ12
      (state == CAP_DR && sel_ident) |=> (id_shift == id_value) && id_shift[ID_START_POS])
      else $error("identification value not captured");

   chk_cell_one: assert property (@(posedge TCK) disable iff (tck_rst) // RQ17
      (state == CAP_DR && sel_chain) |=> boundary_chain[GATE_CELL])
      else $error("internal cell did not capture one");

   chk_chain_order: assert property (@(posedge TCK) disable iff (tck_rst) // RQ22
      (state == SHIFT_DR && sel_chain) |=> (boundary_chain[GATE_CELL] == $past(TDI))
         && (boundary_chain[0] == $past(boundary_chain[1])))
      else $error("boundary chain shifted in wrong order");

   chk_upd_stable: assert property (@(posedge TCK) disable iff (tck_rst) // RQ6
      (state != UPD_DR) |=> $stable(upd_cells))
      else $error("update stage changed outside update-DR");

   chk_tdo_enable: assert property (@(negedge TCK) disable iff (tck_rst) // RQ20
      1'b1 |=> (TDO_OE == $past(in_shift)))
      else $error("data out enabled outside shift states");

   // checks in the core clock domain
   chk_float_hiz: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ7
      (flt_s2 && !ext_s2) |=> !Q_OE)
      else $error("read data driven under float-capture");

   chk_term_off: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ8
      test_owns |=> !INPUT_TERMINATION && !CORE_RUN)
      else $error("termination left on during test");

   chk_extest_pins: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ5
      ext_s2 |=> (Q_OUT == $past(ext_cells[Q_W-1:0])) && (Q_OE == $past(ext_gate)))
      else $error("pins not driven from boundary cells");

endmodule : mtrs_top

// *** tb/mtrs_tap_master.sv ***
`timescale 1ns/1ps
module mtrs_tap_master
(
   // test access port
   output logic TCK,
   output logic TMS,
   output logic TDI,
   input wire logic TDO,
   input wire logic TDO_OE
);
   logic [255:0] got;
   logic oe_ok;
   event done;
   initial
   begin
      TCK = 1'h0;
      TMS = 1'h1;
      TDI = 1'h0;
   end
   // tdo read just before the rise that shifts, once the falling edge has settled it
   task automatic step(input logic m, input logic b, output logic q, output logic e);
      TMS = m;
      TDI = b;
      #40;
      q = TDO;
      e = TDO_OE;
      TCK = 1'h1;
      #40 TCK = 1'h0;
   endtask : step
   // released tdi shows its inverse
   task automatic walk(input int n, input logic m);
      logic q;
      logic e;
      repeat (n) step(m, ~TDI, q, e);
   endtask : walk
   // idle to shift, park in pause
   task automatic scan(input logic ir, input int n, input logic [255:0] din);
      logic q;
      logic e;
      got = '0;
      oe_ok = 1'h1;
      walk(ir ? 2 : 1, 1'h1);
      walk(2, 1'h0);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], q, e);
         got[i] = q;
         oe_ok &= e;
      end
      walk(1, 1'h0);
      -> done;
   endtask : scan
   // pause to update to idle
   task automatic update;
      walk(2, 1'h1);
      walk(1, 1'h0);
   endtask : update
endmodule : mtrs_tap_master

// *** tb/mtrs_top_tb.sv ***
`timescale 1ns/1ps
module mtrs_top_tb;
   import mtrs_pkg::*;
   localparam logic [RING_W-1:0] NC = 128'hf0;
   localparam logic [MAKER_W-1:0] MK = 11'h2a5; // arbitrary value
   localparam logic [DEV_W-1:0] DV = 20'h0c3e9; // arbitrary value
   logic CLOCK, RST_N, TCK, TMS, TDI, TDO, TDO_OE, CORE_VALID, CORE_TERM_EN;
   logic Q_OE, READ_VALID_OUT, INPUT_TERMINATION, CORE_RUN, gate;
   logic [35:0] CORE_Q, Q_OUT;
   logic [1:0] CORE_ECHO, ECHO_CLOCK_OUT;
   logic [RING_W-1:0] RING_IN;
   logic [255:0] d, snap;
   logic [255:0] exp_q[$];
   logic [2:0] bmodes[3] = '{IR_SAMPLE, IR_FLOAT, IR_EXTEST};
   logic [2:0] codes[4] = '{IR_BYPASS, 3'h3, 3'h5, 3'h6};
   int seed, errors, tests_run;
   mtrs_top #(.NC_MASK(NC), .MAKER_CODE(MK), .DEVICE_CODE(DV)) u_mtrs_top (.CLOCK(CLOCK), .RST_N(RST_N),
      .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE), .CORE_Q(CORE_Q), .CORE_VALID(CORE_VALID),
      .CORE_ECHO(CORE_ECHO), .CORE_TERM_EN(CORE_TERM_EN), .RING_IN(RING_IN), .Q_OUT(Q_OUT), .Q_OE(Q_OE),
      .READ_VALID_OUT(READ_VALID_OUT), .ECHO_CLOCK_OUT(ECHO_CLOCK_OUT),
      .INPUT_TERMINATION(INPUT_TERMINATION), .CORE_RUN(CORE_RUN));
   mtrs_tap_master u_mtrs_tap_master (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE));
   always #5 CLOCK = ~CLOCK;
   task automatic cmp(input logic [255:0] g, input logic [255:0] e);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // scan results against the oldest note
   always @(u_mtrs_tap_master.done)
   begin
      cmp(u_mtrs_tap_master.got, exp_q.pop_front());
      cmp(256'(u_mtrs_tap_master.oe_ok), 256'h1);
   end
   task automatic drive;
      @(posedge CLOCK);
      CORE_Q <= 36'({$random(seed), $random(seed)});
      CORE_VALID <= 1'($random(seed));
      CORE_ECHO <= 2'($random(seed));
      CORE_TERM_EN <= 1'($random(seed));
      RING_IN <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      d = 256'({8{$random(seed)}});
      @(posedge CLOCK);
   endtask : drive
   task automatic mode_chk(input logic [2:0] c);
      logic m;
      m = (c == IR_EXTEST) || (c == IR_FLOAT);
      repeat (10) @(posedge CLOCK);
      cmp(256'({CORE_RUN, INPUT_TERMINATION, Q_OE}), 256'({~m, ~m & CORE_TERM_EN, (c == IR_EXTEST) ? gate : ~m}));
      if (!m)
         cmp(256'({ECHO_CLOCK_OUT, READ_VALID_OUT, Q_OUT}), 256'({CORE_ECHO, CORE_VALID, CORE_Q}));
   endtask : mode_chk
   task automatic load_ir(input logic [2:0] c);
      exp_q.push_back(256'h1);
      u_mtrs_tap_master.scan(1'h1, 3, 256'(c));
      u_mtrs_tap_master.update();
      mode_chk(c);
   endtask : load_ir
   task automatic ident;
      exp_q.push_back(256'({d[31:0], DV, MK, ID_START_BIT}));
      u_mtrs_tap_master.scan(1'h0, 64, d);
      u_mtrs_tap_master.update();
      $display("test ident done");
   endtask : ident
   initial
   begin
      {CLOCK, RST_N, CORE_Q, CORE_VALID, CORE_ECHO, RING_IN, gate} = '0;
      CORE_TERM_EN = 1'h1;
      seed = 50;
      errors = 0;
      tests_run = 0;
      fork
         u_mtrs_tap_master.walk(8, 1'h1);
         begin
            repeat (12) @(posedge CLOCK);
            RST_N <= 1'h1;
         end
      join
      u_mtrs_tap_master.walk(1, 1'h0);
      drive();
      ident();
      foreach (codes[k])
      begin
         load_ir(codes[k]);
         drive();
         exp_q.push_back(256'({d[6:0], BYPASS_CAPTURE}));
         u_mtrs_tap_master.scan(1'h0, 8, d);
         u_mtrs_tap_master.update();
         $display("test bypass code %0d done", codes[k]);
      end
      foreach (bmodes[k])
      begin
         load_ir(bmodes[k]);
         drive();
         d[GATE_CELL] = 1'h1;
         u_mtrs_tap_master.walk(2, 1'h0);
         snap = 256'({ECHO_CLOCK_OUT, READ_VALID_OUT, Q_OUT, Q_OE});
         exp_q.push_back(256'({INTERNAL_CAPTURE, RING_IN & ~NC}));
         u_mtrs_tap_master.scan(1'h0, CHAIN_W, d);
         repeat (10) @(posedge CLOCK);
         cmp(256'({ECHO_CLOCK_OUT, READ_VALID_OUT, Q_OUT, Q_OE}), snap);
         u_mtrs_tap_master.update();
         $display("test boundary mode %0d done", bmodes[k]);
      end
      repeat (10) @(posedge CLOCK);
      cmp(256'({Q_OE, ECHO_CLOCK_OUT, READ_VALID_OUT, Q_OUT}), 256'({1'h1, d[38:0]}));
      d[GATE_CELL] = 1'h0;
      exp_q.push_back(256'({INTERNAL_CAPTURE, RING_IN & ~NC}));
      u_mtrs_tap_master.scan(1'h0, CHAIN_W, d);
      u_mtrs_tap_master.update();
      mode_chk(IR_EXTEST);
      $display("test extest done");
      u_mtrs_tap_master.walk(5, 1'h1);
      u_mtrs_tap_master.walk(1, 1'h0);
      mode_chk(IR_IDENT);
      ident();
      cmp(256'(TDO_OE), 256'h0);
      close_out();
   end
   initial
   begin
      #200000;
      errors++;
      close_out();
   end
endmodule : mtrs_top_tb
